// ---- upw_consts.svh ----
// register offsets, field positions, reset values and timing counts of the encapsulator
`ifndef UPW_CONSTS_SVH
`define UPW_CONSTS_SVH
`define UPW_OFS_CTRL      8'h00
`define UPW_OFS_STATUS    8'h04
`define UPW_OFS_IRQ_STAT  8'h08
`define UPW_OFS_IRQ_MASK  8'h0C
`define UPW_OFS_PAYLOAD   8'h10
`define UPW_OFS_MTU       8'h14
`define UPW_OFS_RTP_PT    8'h18
`define UPW_OFS_SSRC      8'h1C
`define UPW_OFS_LOSS      8'h20
`define UPW_OFS_SEQ       8'h24
`define UPW_CTRL_EN       0
`define UPW_CTRL_LINE     2:1
`define UPW_CTRL_DEMUX    4:3
`define UPW_CTRL_RTP      5
`define UPW_CTRL_IPV4     6
`define UPW_CTRL_OMIT     7
`define UPW_EV_SIGLOSS    0
`define UPW_EV_ALARM      1
`define UPW_EV_LOSS       2
`define UPW_EV_MTU        3
`define UPW_EV_OVR        4
`define UPW_RST_PAYLOAD   11'h100
`define UPW_RST_MTU       16'h05DC
`define UPW_RST_OVH       16'h001C
`define UPW_RST_PT        7'h60
`define UPW_RST_SSRC      32'h0000_0000
`define UPW_RST_LOSS_GAP  8'h02
`define UPW_RST_EXIT_CNT  8'h02
`define UPW_LFSR_SEED     16'hACE1
`define UPW_RTP_VER       8'h80
`define UPW_CW_BYTES      5'h04
`define UPW_HDR_RTP_BYTES 5'h10
`define UPW_LEN_LIMIT     12'h040
`define UPW_CLK_NS        50
`define UPW_QUIET_TIME_NS 10000
`define UPW_QUIET_CYC     ((`UPW_QUIET_TIME_NS + `UPW_CLK_NS - 1) / `UPW_CLK_NS)
`define UPW_ONES_RUN      512
`endif

// ---- upw_pkg.sv ----
// types shared by the encapsulator files
package upw_pkg;
  typedef enum logic [2:0] {UPW_IDLE = 3'b001, UPW_HDR = 3'b010, UPW_PAY = 3'b100} upw_tx_state_type;
  typedef enum logic [1:0] {UPW_E1 = 2'h0, UPW_T1 = 2'h1, UPW_E3 = 2'h2, UPW_T3 = 2'h3} upw_line_type;
  typedef enum logic [1:0] {UPW_MPLS = 2'h0, UPW_L2TP = 2'h1, UPW_UDP = 2'h2, UPW_RSVD = 2'h3} upw_demux_type;
endpackage

// ---- upw_ram.sv ----
// two-bank payload memory with registered read data
`timescale 1ns/1ps
module upw_ram
(
  // clock
  input  wire logic        sys_clk_i,
  // write port
  input  wire logic        we_i,
  input  wire logic [10:0] waddr_i,
  input  wire logic [7:0]  wdata_i,
  // read port
  input  wire logic [10:0] raddr_i,
  output logic      [7:0]  rdata_o
);
  logic [7:0] mem [0:2047];

  always_ff @(posedge sys_clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule // upw_ram

// ---- upw_encap.sv ----
// unframed tdm pseudowire encapsulator and decapsulator with ahb-lite registers
// Function
// R1 - every packet header carries the 4-byte control word, with the rtp header only as an optional extra.
// R2 - the rtp header follows the control word, except under udp demultiplexing where it precedes it.
// R3 - a packet plus its outer overhead never exceeds the configured path mtu; larger packets are dropped.
// R4 - with ipv4 selected, every emitted datagram is flagged don't-fragment.
// R5 - the tdm bits are carried transparently with no framing alignment.
// R6 - e1, t1, e3 and t3 line types are supported.
// R7 - the alarm pattern is a run of ones on e1, t1 and e3; on t3 it is not detected here.
// R8 - loss of signal is flagged when no line bits arrive for the loss time.
// R9 - the tdm stream is packed into packets toward the network and unpacked toward the customer edge.
// R10 - the stream is handled the same way whatever carried it to the block.
// R11 - the local-fault flag is set while the line is faulty, payload optionally omitted, and cleared after.
// R12 - the remote-loss flag is set while the receive side is in packet-loss state.
// R13 - control word bits 6 to 9 are zero and ignored; bits 10 to 15 hold the length below 64 bytes, else zero.
// R14 - a 16-bit wrapping sequence number starts from a random value and steps by one per packet.
// R15 - multi-byte header fields leave most significant byte first.
// R16 - demux mode, rtp use and ipv4 selection are fixed while the pseudowire is enabled.
`timescale 1ns/1ps
`include "upw_consts.svh"
module upw_encap
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // tdm line input
  input  wire logic        tdm_valid_i,
  input  wire logic        tdm_bit_i,
  // packet output toward the network
  output logic             pkt_valid_o,
  output logic      [7:0]  pkt_data_o,
  output logic             pkt_sop_o,
  output logic             pkt_eop_o,
  output logic             pkt_df_o,
  // packet input from the network
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_sop_i,
  input  wire logic        rx_eop_i,
  // payload toward the customer edge
  output logic             ce_valid_o,
  output logic      [7:0]  ce_data_o,
  output logic             ce_fault_o,
  // interrupt
  output logic             irq_o
);
  function automatic logic [4:0] hdr_len(input logic rtp);
    hdr_len = rtp ? `UPW_HDR_RTP_BYTES : `UPW_CW_BYTES;
  endfunction

  default clocking upw_cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  logic                      cfg_en;
  upw_pkg::upw_line_type     cfg_line;
  upw_pkg::upw_demux_type    cfg_demux;
  logic                      cfg_rtp;
  logic                      cfg_ipv4;
  logic                      cfg_omit;
  logic [10:0]               cfg_payload;
  logic [15:0]               cfg_mtu;
  logic [15:0]               cfg_ovh;
  logic [6:0]                cfg_pt;
  logic [31:0]               cfg_ssrc;
  logic [7:0]                cfg_loss_gap;
  logic [7:0]                cfg_exit_cnt;
  logic [4:0]                irq_stat;
  logic [4:0]                irq_mask;
  logic [4:0]                ev;
  logic                      wr_pend;
  logic [7:0]                wr_addr;
  logic                      rd_clr;
  logic [31:0]               rd_data;
  logic                      signal_loss_condition;
  logic                      alarm_indication_pattern;
  logic                      fault;
  logic [11:0]               quiet_cnt;
  logic [9:0]                ones_cnt;
  logic [15:0]               lfsr;
  logic                      en_q;
  logic [7:0]                pack_sh;
  logic [2:0]                pack_cnt;
  logic                      wbank;
  logic [9:0]                widx;
  logic                      mem_we;
  logic                      fill_pend;
  logic                      fill_bank;
  logic                      fill_set;
  upw_pkg::upw_tx_state_type tx_state;
  logic [9:0]                tx_idx;
  logic [4:0]                tx_hlen;
  logic                      tx_omit;
  logic                      tx_bank;
  logic [127:0]              tx_hv;
  logic [31:0]               tx_cw;
  logic [15:0]               tx_seq;
  logic                      tx_start;
  logic                      tx_drop;
  logic                      tx_done;
  logic                      mtu_ok;
  logic [11:0]               tot_len;
  logic [31:0]               next_cw;
  logic [95:0]               next_rtp;
  logic [7:0]                mem_rd;
  logic                      s1_valid;
  logic                      s1_sop;
  logic                      s1_eop;
  logic                      s1_hdr;
  logic [7:0]                s1_byte;
  logic [11:0]               rx_cnt;
  logic [11:0]               rx_pos;
  logic [4:0]                rx_cw_off;
  logic [31:0]               rx_cw;
  logic                      rx_done;
  logic                      rx_first;
  logic [15:0]               rx_exp;
  logic [15:0]               rx_gap;
  logic [7:0]                good_cnt;
  logic                      rx_loss;

  // register bus: zero wait states, always okay
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
      wr_pend     <= 1'b0;
      wr_addr     <= 8'h00;
      hrdata_o    <= 32'h0000_0000;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      wr_pend     <= hsel_i && htrans_i[1] && hready_i && hwrite_i && (hsize_i == 3'h2);
      wr_addr     <= haddr_i[7:0];
      if (hsel_i && htrans_i[1] && hready_i && !hwrite_i)
      begin
        hrdata_o <= rd_data;
      end
    end
  end

  assign rd_clr = hsel_i && htrans_i[1] && hready_i && !hwrite_i && (haddr_i[7:0] == `UPW_OFS_IRQ_STAT);

  always_comb
  begin
    unique case (haddr_i[7:0])
      `UPW_OFS_CTRL:     rd_data = {24'h00_0000, cfg_omit, cfg_ipv4, cfg_rtp, cfg_demux, cfg_line, cfg_en};
      `UPW_OFS_STATUS:   rd_data = {27'h000_0000, tx_cw[26], tx_cw[27], rx_loss, alarm_indication_pattern,
                                    signal_loss_condition};
      `UPW_OFS_IRQ_STAT: rd_data = {27'h000_0000, irq_stat};
      `UPW_OFS_IRQ_MASK: rd_data = {27'h000_0000, irq_mask};
      `UPW_OFS_PAYLOAD:  rd_data = {21'h00_0000, cfg_payload};
      `UPW_OFS_MTU:      rd_data = {cfg_ovh, cfg_mtu};
      `UPW_OFS_RTP_PT:   rd_data = {25'h000_0000, cfg_pt};
      `UPW_OFS_SSRC:     rd_data = cfg_ssrc;
      `UPW_OFS_LOSS:     rd_data = {16'h0000, cfg_exit_cnt, cfg_loss_gap};
      `UPW_OFS_SEQ:      rd_data = {rx_exp, tx_seq};
      default:           rd_data = 32'h0000_0000;
    endcase
  end

  // configuration; mode fields only change while the pseudowire is disabled
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cfg_en       <= 1'b0;
      cfg_line     <= upw_pkg::UPW_E1;
      cfg_demux    <= upw_pkg::UPW_MPLS;
      cfg_rtp      <= 1'b0;
      cfg_ipv4     <= 1'b0;
      cfg_omit     <= 1'b0;
      cfg_payload  <= `UPW_RST_PAYLOAD;
      cfg_mtu      <= `UPW_RST_MTU;
      cfg_ovh      <= `UPW_RST_OVH;
      cfg_pt       <= `UPW_RST_PT;
      cfg_ssrc     <= `UPW_RST_SSRC;
      cfg_loss_gap <= `UPW_RST_LOSS_GAP;
      cfg_exit_cnt <= `UPW_RST_EXIT_CNT;
      irq_mask     <= 5'h00;
    end
    else if (wr_pend)
    begin
      unique case (wr_addr)
        `UPW_OFS_CTRL:
        begin
          cfg_en <= hwdata_i[`UPW_CTRL_EN];
          if (!cfg_en) // R16
          begin
            cfg_line  <= upw_pkg::upw_line_type'(hwdata_i[`UPW_CTRL_LINE]); // R6
            cfg_demux <= upw_pkg::upw_demux_type'(hwdata_i[`UPW_CTRL_DEMUX]);
            cfg_rtp   <= hwdata_i[`UPW_CTRL_RTP];
            cfg_ipv4  <= hwdata_i[`UPW_CTRL_IPV4];
            cfg_omit  <= hwdata_i[`UPW_CTRL_OMIT];
            cfg_payload <= cfg_payload;
          end
        end
        `UPW_OFS_IRQ_MASK: irq_mask <= hwdata_i[4:0];
        `UPW_OFS_PAYLOAD:  cfg_payload <= cfg_en ? cfg_payload : hwdata_i[10:0];
        `UPW_OFS_MTU:      {cfg_ovh, cfg_mtu} <= hwdata_i;
        `UPW_OFS_RTP_PT:   cfg_pt <= hwdata_i[6:0];
        `UPW_OFS_SSRC:     cfg_ssrc <= hwdata_i;
        `UPW_OFS_LOSS:     {cfg_exit_cnt, cfg_loss_gap} <= hwdata_i[15:0];
        default:           cfg_en <= cfg_en;
      endcase
    end
  end

  cfg_static_a: assert property (cfg_en && $past(cfg_en) |-> $stable(cfg_rtp) && $stable(cfg_demux)
    && $stable(cfg_ipv4)) else $error("mode changed while enabled"); // R16

  // sticky events, read clears, a new event wins over the clear
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      irq_stat <= 5'h00;
      irq_o    <= 1'b0;
    end
    else
    begin
      irq_stat <= (rd_clr ? 5'h00 : irq_stat) | ev;
      irq_o    <= |(irq_stat & irq_mask);
    end
  end

  irq_level_a: assert property (irq_o == $past(|(irq_stat & irq_mask))) else $error("irq level wrong");

  // line supervision: loss of signal and the all-ones alarm
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      quiet_cnt                <= 12'h000;
      ones_cnt                 <= 10'h000;
      signal_loss_condition    <= 1'b0;
      alarm_indication_pattern <= 1'b0;
    end
    else
    begin
      if (tdm_valid_i)
      begin
        quiet_cnt             <= 12'h000;
        signal_loss_condition <= 1'b0; // R8
        ones_cnt <= tdm_bit_i ? ((ones_cnt == 10'(`UPW_ONES_RUN)) ? ones_cnt : ones_cnt + 10'h001) : 10'h000;
      end
      else if (quiet_cnt != 12'(`UPW_QUIET_CYC))
      begin
        quiet_cnt <= quiet_cnt + 12'h001;
      end
      else
      begin
        signal_loss_condition <= 1'b1; // R8
      end
      // framing is needed for the t3 alarm, so it is never raised on t3
      alarm_indication_pattern <= (ones_cnt == 10'(`UPW_ONES_RUN)) && (cfg_line != upw_pkg::UPW_T3); // R7
    end
  end

  assign fault = signal_loss_condition || alarm_indication_pattern;
  assign ev[`UPW_EV_SIGLOSS] = (quiet_cnt == 12'(`UPW_QUIET_CYC)) && !signal_loss_condition && !tdm_valid_i;
  assign ev[`UPW_EV_ALARM]   = (ones_cnt == 10'(`UPW_ONES_RUN)) && !alarm_indication_pattern
                               && (cfg_line != upw_pkg::UPW_T3);

  // the flag lands one edge after the count runs out
  sigloss_detect_a: assert property (!tdm_valid_i [*2] ##0 quiet_cnt == 12'(`UPW_QUIET_CYC) // R8
    |=> signal_loss_condition) else $error("loss of signal missed");
  alarm_t3_a: assert property (cfg_line == upw_pkg::UPW_T3 && $past(cfg_line) == upw_pkg::UPW_T3 // R7
    |-> !alarm_indication_pattern) else $error("alarm raised on t3");

  // free-running scrambler seeds the sequence number at enable
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      lfsr <= `UPW_LFSR_SEED;
      en_q <= 1'b0;
    end
    else
    begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[14] ^ lfsr[12] ^ lfsr[3]};
      en_q <= cfg_en;
    end
  end

  // bit packer: msb first, no byte or frame alignment sought
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pack_sh  <= 8'h00;
      pack_cnt <= 3'h0;
      wbank    <= 1'b0;
      widx     <= 10'h000;
      mem_we   <= 1'b0;
    end
    else
    begin
      mem_we <= 1'b0;
      if (!cfg_en)
      begin
        pack_cnt <= 3'h0;
        widx     <= 10'h000;
      end
      else if (tdm_valid_i) // R5 R10
      begin
        pack_sh  <= {pack_sh[6:0], tdm_bit_i};
        pack_cnt <= pack_cnt + 3'h1;
        mem_we   <= (pack_cnt == 3'h7);
      end
      if (mem_we)
      begin
        widx <= ({1'b0, widx} == cfg_payload - 11'h001) ? 10'h000 : widx + 10'h001;
        wbank <= ({1'b0, widx} == cfg_payload - 11'h001) ? ~wbank : wbank;
      end
    end
  end

  assign fill_set = mem_we && ({1'b0, widx} == cfg_payload - 11'h001);

  upw_ram u_ram
  (
    .sys_clk_i (sys_clk_i),
    .we_i      (mem_we),
    .waddr_i   ({wbank, widx}),
    .wdata_i   (pack_sh),
    .raddr_i   ({tx_bank, tx_idx}),
    .rdata_o   (mem_rd)
  );

  // a filled bank waits here; a second fill before it is sent is an overrun
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      fill_pend <= 1'b0;
      fill_bank <= 1'b0;
    end
    else
    begin
      fill_pend <= fill_set || (fill_pend && !(tx_done || tx_drop));
      if (fill_set)
      begin
        fill_bank <= wbank;
      end
    end
  end

  assign ev[`UPW_EV_OVR] = fill_set && fill_pend && !(tx_done || tx_drop);

  // header assembly
  always_comb
  begin
    tot_len  = {7'h00, hdr_len(cfg_rtp)} + ((cfg_omit && fault) ? 12'h000 : {1'b0, cfg_payload}); // R11
    mtu_ok   = ({5'h00, tot_len} + {1'b0, cfg_ovh}) <= {1'b0, cfg_mtu}; // R3
    next_cw  = {4'h0, fault, rx_loss, 4'h0, (tot_len < `UPW_LEN_LIMIT) ? tot_len[5:0] : 6'h00, tx_seq}; // R11 R12 R13
    next_rtp = {`UPW_RTP_VER, 1'b0, cfg_pt, tx_seq, 32'h0000_0000, cfg_ssrc};
  end

  assign tx_start = (tx_state == upw_pkg::UPW_IDLE) && fill_pend && cfg_en && mtu_ok;
  assign tx_drop  = (tx_state == upw_pkg::UPW_IDLE) && fill_pend && (!cfg_en || !mtu_ok);
  assign tx_done  = ((tx_state == upw_pkg::UPW_HDR) && tx_omit && ({5'h00, tx_idx} == tx_hlen - 5'h01))
                 || ((tx_state == upw_pkg::UPW_PAY) && ({1'b0, tx_idx} == cfg_payload - 11'h001));
  assign ev[`UPW_EV_MTU] = tx_drop && cfg_en;

  // transmit sequencer
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tx_state <= upw_pkg::UPW_IDLE;
      tx_idx   <= 10'h000;
      tx_hlen  <= 5'h00;
      tx_omit  <= 1'b0;
      tx_bank  <= 1'b0;
      tx_hv    <= 128'h0;
      tx_cw    <= 32'h0000_0000;
      tx_seq   <= 16'h0000;
    end
    else
    begin
      if (cfg_en && !en_q)
      begin
        tx_seq <= lfsr; // R14
      end
      unique case (tx_state)
        upw_pkg::UPW_IDLE:
        begin
          tx_idx <= 10'h000;
          if (tx_start) // R9
          begin
            tx_state <= upw_pkg::UPW_HDR;
            tx_hlen  <= hdr_len(cfg_rtp);
            tx_omit  <= cfg_omit && fault; // R11
            tx_bank  <= fill_bank;
            tx_cw    <= next_cw;
            tx_seq   <= tx_seq + 16'h0001; // R14
            if (!cfg_rtp)
              tx_hv <= {next_cw, 96'h0}; // R1
            else if (cfg_demux == upw_pkg::UPW_UDP)
              tx_hv <= {next_rtp, next_cw}; // R2
            else
              tx_hv <= {next_cw, next_rtp}; // R2
          end
        end
        upw_pkg::UPW_HDR:
        begin
          tx_hv <= {tx_hv[119:0], 8'h00}; // R15
          if ({5'h00, tx_idx} == tx_hlen - 5'h01)
          begin
            tx_idx   <= 10'h000;
            tx_state <= tx_omit ? upw_pkg::UPW_IDLE : upw_pkg::UPW_PAY;
          end
          else
          begin
            tx_idx <= tx_idx + 10'h001;
          end
        end
        upw_pkg::UPW_PAY:
        begin
          tx_idx <= tx_idx + 10'h001;
          if (tx_done)
          begin
            tx_state <= upw_pkg::UPW_IDLE;
          end
        end
        default: tx_state <= upw_pkg::UPW_IDLE;
      endcase
    end
  end

  seq_step_a: assert property (tx_start |=> tx_seq == $past(tx_seq) + 16'h0001) else $error("seq step"); // R14
  cw_zero_a: assert property (tx_start |=> tx_cw[31:28] == 4'h0 && tx_cw[25:22] == 4'h0)
    else $error("reserved control bits set"); // R13
  lbit_follow_a: assert property (tx_start |=> tx_cw[27] == $past(fault)) else $error("fault flag wrong"); // R11
  rbit_follow_a: assert property (tx_start |=> tx_cw[26] == $past(rx_loss)) else $error("loss flag wrong"); // R12
  mtu_drop_a: assert property (tx_state == upw_pkg::UPW_IDLE && fill_pend && cfg_en && !mtu_ok
    |=> tx_state == upw_pkg::UPW_IDLE && irq_stat[`UPW_EV_MTU]) else $error("oversize packet sent"); // R3

  // output pipeline: header bytes and memory data meet the same register stage
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s1_valid    <= 1'b0;
      s1_sop      <= 1'b0;
      s1_eop      <= 1'b0;
      s1_hdr      <= 1'b0;
      s1_byte     <= 8'h00;
      pkt_valid_o <= 1'b0;
      pkt_sop_o   <= 1'b0;
      pkt_eop_o   <= 1'b0;
      pkt_data_o  <= 8'h00;
      pkt_df_o    <= 1'b0;
    end
    else
    begin
      s1_valid    <= tx_state != upw_pkg::UPW_IDLE;
      s1_sop      <= (tx_state == upw_pkg::UPW_HDR) && (tx_idx == 10'h000);
      s1_eop      <= tx_done;
      s1_hdr      <= tx_state == upw_pkg::UPW_HDR;
      s1_byte     <= tx_hv[127:120];
      pkt_valid_o <= s1_valid;
      pkt_sop_o   <= s1_sop;
      pkt_eop_o   <= s1_eop;
      pkt_data_o  <= s1_hdr ? s1_byte : mem_rd;
      pkt_df_o    <= cfg_ipv4; // R4
    end
  end

  sop_walk_a: assert property (tx_start |-> ##3 pkt_sop_o && pkt_valid_o) else $error("packet start late"); // R9
  df_flag_a: assert property (pkt_valid_o && cfg_ipv4 && $past(cfg_ipv4) |-> pkt_df_o)
    else $error("df flag missing"); // R4
  rtp_first_a: assert property (pkt_sop_o && cfg_rtp && cfg_demux == upw_pkg::UPW_UDP |-> pkt_data_o == `UPW_RTP_VER)
    else $error("rtp not first under udp"); // R2
  cw_first_a: assert property (pkt_sop_o && !(cfg_rtp && cfg_demux == upw_pkg::UPW_UDP) |-> pkt_data_o[7:4] == 4'h0)
    else $error("control word not first"); // R1

  // receive: strip the header, pass payload on, track sequence
  assign rx_pos    = rx_sop_i ? 12'h000 : rx_cnt;
  assign rx_cw_off = (cfg_rtp && cfg_demux == upw_pkg::UPW_UDP) ? 5'h0C : 5'h00;
  assign rx_gap    = rx_cw[15:0] - rx_exp;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rx_cnt     <= 12'h000;
      rx_cw      <= 32'h0000_0000;
      rx_done    <= 1'b0;
      ce_valid_o <= 1'b0;
      ce_data_o  <= 8'h00;
    end
    else
    begin
      rx_done    <= rx_valid_i && rx_eop_i;
      ce_valid_o <= 1'b0;
      if (rx_valid_i)
      begin
        rx_cnt    <= rx_pos + 12'h001;
        ce_data_o <= rx_data_i;
        if (rx_pos >= {7'h00, rx_cw_off} && rx_pos < {7'h00, rx_cw_off + 5'h04})
        begin
          rx_cw <= {rx_cw[23:0], rx_data_i}; // R15
        end
        // bits 6 to 9 of the received word are never looked at
        ce_valid_o <= cfg_en && (rx_pos >= {7'h00, hdr_len(cfg_rtp)}) && !rx_cw[27]; // R9 R13
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rx_first   <= 1'b1;
      rx_exp     <= 16'h0000;
      good_cnt   <= 8'h00;
      rx_loss    <= 1'b0;
      ce_fault_o <= 1'b0;
    end
    else if (rx_done)
    begin
      rx_first   <= 1'b0;
      rx_exp     <= rx_cw[15:0] + 16'h0001;
      ce_fault_o <= rx_cw[27];
      if (rx_first || rx_gap == 16'h0000)
      begin
        good_cnt <= (good_cnt == 8'hFF) ? good_cnt : good_cnt + 8'h01;
        if (rx_loss && (good_cnt + 8'h01 >= cfg_exit_cnt))
          rx_loss <= 1'b0; // R12
      end
      else
      begin
        good_cnt <= 8'h00;
        if (rx_gap >= {8'h00, cfg_loss_gap})
          rx_loss <= 1'b1; // R12
      end
    end
  end

  assign ev[`UPW_EV_LOSS] = rx_done && !rx_first && !rx_loss && (rx_gap >= {8'h00, cfg_loss_gap});
endmodule // upw_encap

// ---- upw_line_src.sv ----
// tdm line source model, one bit every other cycle
`timescale 1ns/1ps
module upw_line_src
(
  // clock and control
  input  wire logic sys_clk_i,
  input  wire logic run_i,
  // line
  output logic      valid_o,
  output logic      bit_o
);
  logic [10:0] cnt = '0;
  logic [7:0]  pat;
  assign pat = cnt[10:3] ^ 8'hA5;
  // released line shows the inverse of its last bit, not a stale copy
  always_ff @(posedge sys_clk_i)
  begin
    valid_o <= run_i & ~valid_o;
    bit_o <= (run_i & ~valid_o) ? pat[~cnt[2:0]] : ~bit_o;
    if (run_i & ~valid_o)
      cnt <= cnt + 11'h001;
  end
endmodule // upw_line_src

// ---- tb_upw_encap.sv ----
// testbench of the encapsulator: registers, tx packets, loopback rx, irq
`timescale 1ns/1ps
module tb_upw_encap;
  logic clk, rst, hsel, hwrite, hready, hresp, tv, tb, run;
  logic pv, ps, pe, df, cv, cf, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  pd, cd;
  logic [31:0] haddr, hwdata, hrdata, r, s;
  logic [7:0]  q[$], c[$];
  int          mismatches = 0, n_checks = 0;
  upw_encap u_upw_encap (.sys_clk_i(clk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .tdm_valid_i(tv), .tdm_bit_i(tb),
    .pkt_valid_o(pv), .pkt_data_o(pd), .pkt_sop_o(ps), .pkt_eop_o(pe), .pkt_df_o(df),
    .rx_valid_i(pv), .rx_data_i(pd), .rx_sop_i(ps), .rx_eop_i(pe),
    .ce_valid_o(cv), .ce_data_o(cd), .ce_fault_o(cf), .irq_o(irq));
  upw_line_src u_upw_line_src (.sys_clk_i(clk), .run_i(run), .valid_o(tv), .bit_o(tb));
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (pv === 1'b1) q.push_back(pd);
    if (cv === 1'b1) c.push_back(cd);
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1; htrans <= 2'b10; haddr <= {24'h0000_00, a}; hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 0; htrans <= 2'b00; hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic chk(input string n, input logic [31:0] v, input logic [31:0] e);
    n_checks++;
    if (v !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish;
  end
  initial
  begin
    rst = 1; hsel = 0; htrans = 0; haddr = 0; hwrite = 0; hsize = 3'b010; hwdata = 0; run = 0;
    repeat (20) @(posedge clk);
    rst <= 0;
    bus(0, 8'h10, 0); chk("payload", r, 32'h0000_0100);
    bus(0, 8'h14, 0); chk("mtu", r, 32'h001C_05DC);
    bus(0, 8'h18, 0); chk("pt", r, 32'h0000_0060);
    bus(0, 8'h40, 0); chk("unmapped", r, 32'h0000_0000);
    chk("resp", hresp, 0);
    bus(1, 8'h0C, 32'h0000_001F);
    bus(1, 8'h10, 32'h0000_0008);
    bus(1, 8'h00, 32'h0000_0041);
    bus(0, 8'h24, 0); s = r;
    run <= 1;
    while (q.size() < 24) @(posedge clk);
    run <= 0;
    chk("df", df, 1);
    for (int p = 0; p < 2; p++)
    begin
      chk("cw0", q[12*p], 0);
      chk("cw1", q[12*p+1], 12);
      chk("seq", {q[12*p+2], q[12*p+3]}, 16'(s[15:0] + 16'(p)));
      for (int k = 0; k < 8; k++)
        chk("pay", q[12*p+4+k], (8*p+k) ^ 8'hA5);
    end
    repeat (260) @(posedge clk);
    for (int k = 0; k < 16; k++)
      chk("ce", c[k], k ^ 8'hA5);
    chk("cefault", cf, 0);
    chk("irq", irq, 1);
    bus(0, 8'h04, 0); chk("sigloss", r[0], 1);
    bus(0, 8'h08, 0); chk("stat", r[0], 1);
    bus(0, 8'h08, 0); chk("clr", r, 0);
    bus(1, 8'h14, 32'h001C_0027);
    run <= 1;
    repeat (300) @(posedge clk);
    chk("drop", q.size(), 24);
    bus(0, 8'h08, 0); chk("mtuirq", r[3], 1);
    // udp demux with rtp: rtp header ahead of the control word
    bus(1, 8'h00, 32'h0000_0000);
    bus(1, 8'h14, 32'h001C_05DC);
    q.delete();
    bus(1, 8'h00, 32'h0000_0071);
    bus(0, 8'h24, 0); s = r;
    while (q.size() < 24) @(posedge clk);
    chk("rtpver", q[0], 32'h0000_0080);
    chk("rtppt", q[1], 32'h0000_0060);
    chk("rtpseq", {q[2], q[3]}, s[15:0]);
    chk("udpcw0", q[12], 0);
    chk("udplen", q[13], 32'h0000_0018);
    chk("udpseq", {q[14], q[15]}, s[15:0]);
    tally_and_finish;
  end
endmodule // tb_upw_encap
